// *** rtl/self_program_mode_guard.v ***
// Guarded mode switch between normal and self-programming flash mode.
// Assumes CPU register writes arrive as single-cycle strobes on core_clk_in.
`timescale 1ns/10ps
`include "spm_guard_consts.vh"

module self_program_mode_guard (
  input wire core_clk_in,              // CPU clock, 125 MHz
  input wire resetn_in,                // Async reset, active low
  input wire protect_cmd_wr_in,        // Write strobe, protection command
  input wire mode_ctrl_wr_in,          // Write strobe, mode control
  input wire status_wr_in,             // Write strobe, flash status
  input wire [7:0] wr_data_in,         // Write data for all strobes
  input wire [4:0] block_protect_in,   // Block protection setting
  input wire [4:0] target_block_in,    // Block addressed by a write/erase
  output reg self_prog_mode_out,       // High in self-programming mode
  output reg [7:0] flash_mode_control_out, // Mode control readback
  output reg [7:0] flash_status_out,   // Flash status readback
  output reg guarded_sequence_error_out, // Status bit 0 copy
  output reg block_access_ok_out,      // Target block may be written
  output reg protect_illegal_out       // Prohibited protection encoding
);

  // Tracker states; one per step of the guarded chain
  localparam ST_IDLE = 2'h0;   // Waiting for the unlock
  localparam ST_FIRST = 2'h1;  // Unlocked, first mode value due
  localparam ST_INVERT = 2'h2; // Inverse of the first value due
  localparam ST_FINAL = 2'h3;  // Repeat of the first value due

  // Tracker state and the value captured by the first mode write
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [7:0] value_reg;
  reg [7:0] value_next;

  // Per-cycle decisions of the tracker
  reg fail;   // Chain broken this cycle
  reg commit; // Chain completed this cycle

  // Data comparisons, kept apart so the tracker reads plainly
  reg unlock_hit;
  reg inverse_hit;
  reg repeat_hit;

  // Architectural registers and their next values
  reg [7:0] flash_mode_control_reg;
  reg [7:0] flash_mode_control_next;
  reg [7:0] flash_status_reg;
  reg [7:0] flash_status_next;

  // Protection decode results
  reg prot_ok;
  reg prot_bad;

  // Write data against the unlock code and the remembered value
  always @* begin
    unlock_hit = (wr_data_in == `UNLOCK_CODE);
    inverse_hit = (wr_data_in == ~value_reg);
    repeat_hit = (wr_data_in == value_reg);
  end

  // Sequence tracker; any out-of-order write other than an unlock aborts and flags failure.
  // A fresh unlock always restarts the chain, so software that retries
  // after an error needs no extra step here.
  always @* begin
    state_next = state_reg;
    value_next = value_reg;
    fail = 1'b0;
    commit = 1'b0;
    if (protect_cmd_wr_in) begin
      // Only the unlock code opens the chain
      if (unlock_hit) begin
        state_next = ST_FIRST;
      end else begin
        state_next = ST_IDLE;
        fail = 1'b1;
      end
    end else if (mode_ctrl_wr_in) begin
      case (state_reg)
        ST_FIRST: begin
          // First value is only remembered; the register keeps its content
          value_next = wr_data_in;
          state_next = ST_INVERT;
        end
        ST_INVERT: begin
          // Second write must be the exact bitwise inverse
          if (inverse_hit) begin
            state_next = ST_FINAL;
          end else begin
            state_next = ST_IDLE;
            fail = 1'b1;
          end
        end
        ST_FINAL: begin
          // Third write must repeat the first; only then the mode moves
          state_next = ST_IDLE;
          if (repeat_hit) begin
            commit = 1'b1;
          end else begin
            fail = 1'b1;
          end
        end
        default: begin
          // Mode write without a preceding unlock is refused
          state_next = ST_IDLE;
          fail = 1'b1;
        end
      endcase
    end else if (status_wr_in && state_reg != ST_IDLE) begin
      // Any other register write breaks the guarded chain
      state_next = ST_IDLE;
      fail = 1'b1;
    end
  end

  // Block protection decode; unknown encodings deny all access.
  // Denying on a prohibited code is the safe side: a stray setting
  // can never open the low blocks by accident.
  always @* begin
    prot_bad = 1'b0;
    prot_ok = 1'b1;
    case (block_protect_in)
      `PROT_ALL_OPEN: begin
        prot_ok = 1'b1;
      end
      `PROT_LOW2: begin
        // Blocks 0 and 1 stay locked, the rest may be written
        prot_ok = (target_block_in > 5'h01);
      end
      default: begin
        prot_ok = 1'b0;
        prot_bad = 1'b1;
      end
    endcase
  end

  // Mode register next value; only a completed triple moves it
  always @* begin
    flash_mode_control_next = flash_mode_control_reg;
    if (commit) begin
      flash_mode_control_next = value_reg;
    end
  end

  // Status next value; hardware error set wins over a software clear,
  // so a clear racing a broken chain can never hide the failure
  always @* begin
    flash_status_next = flash_status_reg;
    if (status_wr_in) begin
      flash_status_next = wr_data_in;
    end
    if (fail) begin
      flash_status_next[`STATUS_ERR_BIT] = 1'b1;
    end
  end

  // Tracker registers; reset drops any half-done chain
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= ST_IDLE;
      value_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      value_reg <= value_next;
    end
  end

  // Mode control and flash status registers
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flash_mode_control_reg <= `MODE_RESET;
      flash_status_reg <= `STATUS_RESET;
    end else begin
      flash_mode_control_reg <= flash_mode_control_next;
      flash_status_reg <= flash_status_next;
    end
  end

  // Output stage, one clock behind the registers and the protection decode. The extra cycle of
  // latency buys outputs that come straight from flip-flops.
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      self_prog_mode_out <= 1'b0;
      flash_mode_control_out <= `MODE_RESET;
      flash_status_out <= `STATUS_RESET;
      guarded_sequence_error_out <= 1'b0;
      block_access_ok_out <= 1'b0;
      protect_illegal_out <= 1'b0;
    end else begin
      self_prog_mode_out <= flash_mode_control_reg[0];
      flash_mode_control_out <= flash_mode_control_reg;
      flash_status_out <= flash_status_reg;
      guarded_sequence_error_out <= flash_status_reg[`STATUS_ERR_BIT];
      // Access needs self-programming mode and an unprotected block
      block_access_ok_out <= prot_ok & flash_mode_control_reg[0];
      protect_illegal_out <= prot_bad;
    end
  end

endmodule

// *** rtl/spm_guard_consts.vh ***
// Constants for the self-programming mode guard
// Assumes inclusion by the guard module and its port checker
`ifndef SPM_GUARD_CONSTS_VH
`define SPM_GUARD_CONSTS_VH
`define UNLOCK_CODE 8'hA5
`define MODE_SELF_PROG 8'h01
`define MODE_NORMAL 8'h00
`define MODE_RESET 8'h00
`define STATUS_RESET 8'h00
`define STATUS_ERR_BIT 0
`define PROT_ALL_OPEN 5'h1F
`define PROT_LOW2 5'h0F
`define PROT_RESET 5'h1F
`endif

// *** sim/cpu_writer.sv ***
// CPU store model driving the guard's write strobes
// Assumes a free-running clock; stores land at falling edges
`timescale 1ns/10ps
module cpu_writer (
  input wire clk_in, // CPU clock
  output reg [2:0] wr_out, // Protect, mode, status strobes
  output reg [7:0] data_out // Store data
);
  initial begin wr_out = 3'h0; data_out = 8'h00; end
  // Sequence code lives in this block, so it is never a write target
  localparam [4:0] CODE_BLOCK = 5'h1F;
  // Interrupt masks and disable state of the modelled CPU
  reg [7:0] interrupt_mask_low = 8'h00;
  reg [7:0] interrupt_mask_high = 8'h00;
  reg [15:0] saved_masks = 16'h0000;
  reg ints_off = 1'b0;
  // One store; released bus shows inverted data, never stale
  task st(input [2:0] k, input [7:0] v);
    @(negedge clk_in); wr_out = k; data_out = v;
    @(negedge clk_in); wr_out = 3'h0; data_out = ~v;
  endtask
  // Clear status, unlock, value, inverse, value
  task seq(input [7:0] u, v, i);
    if (v[0]) begin
      saved_masks = {interrupt_mask_high, interrupt_mask_low};
      interrupt_mask_low = 8'hFF;
      interrupt_mask_high = 8'hFF;
      ints_off = 1'b1;
    end
    st(3'h1, 8'h00); st(3'h4, u); st(3'h2, v); st(3'h2, i); st(3'h2, v);
    if (!v[0]) begin
      ints_off = 1'b0;
      {interrupt_mask_high, interrupt_mask_low} = saved_masks;
    end
  endtask
endmodule

// *** sim/spm_guard_chk.sv ***
// Port assertions for the mode guard
// Assumes it is bound onto the guard below
`timescale 1ns/10ps
`include "spm_guard_consts.vh"
module spm_guard_chk (
  input logic core_clk_in, resetn_in, protect_cmd_wr_in, mode_ctrl_wr_in, status_wr_in,
  input logic [7:0] wr_data_in, flash_mode_control_out, flash_status_out,
  input logic [4:0] block_protect_in, target_block_in,
  input logic self_prog_mode_out, guarded_sequence_error_out, block_access_ok_out,
  input logic protect_illegal_out
);
  wire [7:0] mc = flash_mode_control_out;
  wire [4:0] bp = block_protect_in;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  // Mode moves two edges after a mode write, to that write's data
  AST_MODE_CAUSE: assert property ($changed(mc) |-> $past(mode_ctrl_wr_in, 2))
    else $error("mode changed without write");
  AST_MODE_VALUE: assert property ($changed(mc) |-> mc == $past(wr_data_in, 2))
    else $error("mode value wrong");
  AST_MODE_BIT: assert property (self_prog_mode_out == mc[0])
    else $error("mode bit mismatch");
  AST_BAD_UNLOCK: assert property (protect_cmd_wr_in && wr_data_in != `UNLOCK_CODE
    |-> ##2 flash_status_out[0]) else $error("bad unlock not flagged");
  // Error only ever follows a write, and never with a mode change
  AST_ERR_CAUSE: assert property ($rose(flash_status_out[0])
    |-> $past(protect_cmd_wr_in | mode_ctrl_wr_in | status_wr_in, 2)) else $error("error cause");
  AST_ERR_KEEP: assert property ($rose(guarded_sequence_error_out) |-> $stable(mc))
    else $error("mode moved on error");
  AST_ILLEGAL: assert property (protect_illegal_out ==
    !($past(bp) inside {`PROT_ALL_OPEN, `PROT_LOW2})) else $error("illegal flag wrong");
  AST_LOW_PROT: assert property ($past(bp) == `PROT_LOW2 && $past(target_block_in) < 2
    |-> !block_access_ok_out) else $error("protected block open");
  AST_ACCESS_MODE: assert property (block_access_ok_out |-> self_prog_mode_out)
    else $error("access open outside self-programming");
endmodule
bind self_program_mode_guard spm_guard_chk chk_u (.*);

// *** sim/tb.sv ***
// Self-checking bench: random guarded sequences against a reference
// Assumes the guard, checker and CPU model compile alongside
`timescale 1ns/10ps
module tb;
  reg clk = 1'b0, rst_n = 1'b0;
  reg [4:0] bp = 5'h1F, tgt = 5'h00;
  reg [7:0] u, v, x;
  wire [2:0] wr;
  wire [7:0] d, mc, st;
  wire sp, er, ok, il;
  integer num_errors = 0, check_count = 0, m = 0, e = 0, i;
  initial forever #4 clk = ~clk;
  cpu_writer cpu_u (.clk_in(clk), .wr_out(wr), .data_out(d));
  self_program_mode_guard dut_u (.core_clk_in(clk), .resetn_in(rst_n), .protect_cmd_wr_in(wr[2]),
    .mode_ctrl_wr_in(wr[1]), .status_wr_in(wr[0]), .wr_data_in(d), .block_protect_in(bp),
    .target_block_in(tgt), .self_prog_mode_out(sp), .flash_mode_control_out(mc),
    .flash_status_out(st), .guarded_sequence_error_out(er), .block_access_ok_out(ok),
    .protect_illegal_out(il));
  task chk(input [7:0] g, y);
    check_count = check_count + 1;
    if (g !== y) begin
      $display("Error at %0t: got %h expected %h", $time, g, y);
      num_errors = num_errors + 1;
    end
  endtask
  task finish_test;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Bad unlocks and inverses are mixed in so refusals get hit
  initial begin
    void'($urandom(32'hBE97DC63));
    repeat (5) @(negedge clk);
    chk(mc | st, 8'h00);
    rst_n = 1'b1;
    for (i = 0; i < 24; i = i + 1) begin
      u = ($urandom % 3) ? 8'hA5 : $urandom;
      v = {7'h00, i[0]};
      x = ($urandom % 4) ? ~v : $urandom;
      bp = ($urandom % 2) ? 5'h1F : (($urandom % 2) ? 5'h0F : $urandom);
      tgt = $urandom % cpu_u.CODE_BLOCK;
      cpu_u.seq(u, v, x);
      e = !(u == 8'hA5 && x == ~v);
      if (!e) m = v;
      repeat (3) @(negedge clk);
      chk(mc, m);
      chk(st, e);
      chk({er, sp}, {e[0], m[0]});
      chk(il, !(bp == 5'h1F || bp == 5'h0F));
      chk(ok, m[0] && (bp == 5'h1F || bp == 5'h0F && tgt > 1));
    end
    // Status write inside a chain aborts it; a bare mode write is refused
    cpu_u.st(3'h1, 8'h00);
    cpu_u.st(3'h4, 8'hA5);
    cpu_u.st(3'h1, 8'h00);
    cpu_u.st(3'h2, 8'h01);
    repeat (3) @(negedge clk);
    chk(st, 8'h01);
    chk(mc, m);
    // Mid-run reset with a legal protection code, then a fresh entry
    bp = 5'h1F;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk({mc | st, sp, er, ok, il}, 12'h000);
    rst_n = 1'b1;
    cpu_u.seq(8'hA5, 8'h01, 8'hFE);
    repeat (3) @(negedge clk);
    chk(mc, 8'h01);
    chk({er, sp}, 2'b01);
    finish_test;
  end
endmodule
